// *** pkg/rbs_cfg.svh ***
/*
  Constants for the reset, boot and standby vectoring block: addresses,
  entry codes, register offsets and timing figures.
  Assumes a single 50 MHz clock and byte addressing on the register bus.
*/
`ifndef RBS_CFG_SVH
`define RBS_CFG_SVH

// ==========================================================
// instruction and Y data memory map
`define RBS_BOOTROM_LAST 16'h00FF
`define RBS_VEC_BASE 16'h0200
`define RBS_VEC_LAST 16'h023F
`define RBS_VEC_IRQ 16'h0210
`define RBS_LOW_LO 16'h0200
`define RBS_LOW_HI 16'h0FFF
`define RBS_HIGH_LO 16'h4000
`define RBS_HIGH_HI 16'hBFFF
`define RBS_YPARAM 16'h4000

// ==========================================================
// boot ROM entry codes
`define RBS_C_SELF_YW 4'h1
`define RBS_C_SELF_XW 4'h2
`define RBS_C_SELF_YB 4'h3
`define RBS_C_SELF_XB 4'h4
`define RBS_C_HOST_ROM 4'h5
`define RBS_C_HOST_RAM 4'h6
`define RBS_C_SIG 4'h9
`define RBS_C_BOOT_SELF 4'hC
`define RBS_C_BOOT_HOST 4'hD

// ==========================================================
// register offsets
`define RBS_R_MASK 8'h00
`define RBS_R_STEP 8'h04
`define RBS_R_PTR3 8'h08
`define RBS_R_PTR7 8'h0C
`define RBS_R_CALL 8'h10
`define RBS_R_STAT 8'h14
`define RBS_R_PEND 8'h18
`define RBS_R_RES 8'h1C

// ==========================================================
// timing
`define RBS_CLK_MHZ 50
`define RBS_HALT_EXIT_CYC 16'h0020
`define RBS_STOP_EXIT_US 300
`define RBS_SETTLE 16'h0003
`define RBS_RAM_HALT_DIV 8

`endif

// *** pkg/rbs_pkg.sv ***
/*
  Types for the reset, boot and standby vectoring block.
  Assumes rbs_cfg.svh for all numeric constants.
*/
package rbs_pkg;

  // ==========================================================
  // control states
  typedef enum logic [2:0] {
    RBS_BOOT, RBS_BOOTW, RBS_RUN, RBS_OPW,
    RBS_HALT, RBS_HEXIT, RBS_STOP, RBS_SEXIT
  } rbs_st_e;

  // ==========================================================
  // complete state of the block
  typedef struct packed {
    rbs_st_e st;
    logic [9:0] pend;
    logic [9:0] mask;
    logic [15:0] cnt;
    logic [3:0] dcnt;
    logic sco;
    logic [15:0] fa;
    logic fp;
    logic core_run;
    logic clk_run;
    logic [3:0] code;
    logic go;
    logic [15:0] src;
    logic [15:0] dst;
    logic [15:0] steps;
    logic [15:0] pointer_three;
    logic [15:0] pointer_seven;
    logic [39:0] general_reg_seven;
    logic err;
    logic [1:0] bmode;
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] prv;
    logic [1:0] b1;
    logic [1:0] b2;
    logic awok;
    logic wok;
    logic [7:0] awa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bv;
    logic [1:0] bresp;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rresp;
  } rbs_state_s;

endpackage

// *** core/rbs_core.sv ***
/*
  Reset, boot dispatch, standby control and interrupt vectoring for a
  16-bit signal processor, with an AXI4-Lite register slave.
  Assumes: core-side strobes are on aclk; interrupt and boot-select pins
  are asynchronous and active low where marked _n.
*/
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
// Summary of operation
// RL1: vectors and reset fetch from 0x200-0x23F
// RL2: four slots per source from 0x210
// RL3: execution starts at 0x200 after boot
// RL4: low-rate idle stops all but clock
// RL5: idle left by interrupt or reset
// RL6: interrupt exit from idle takes tens
// RL7: idle clock divided by option ratio
// RL8: clock out high one normal cycle
// RL9: full stop halts clock and PLL too
// RL10: stop left only by reset or release
// RL11: release restart takes hundreds of microseconds
// RL12: shared pin releases stop without vectoring
// RL13: build option enables release pin
// RL14: 64K word space, boot ROM bottom
// RL15: self boot parameter at Y 0x4000
// RL16: host boot loads code through host port
// RL17: self reboot entries one to four
// RL18: host reboot entry five or six
// RL19: check value entry nine to register seven
// RL20: no operation spans both RAM regions
// RL21: boot selects choose none, host, self
// RL22: full clock restored before vectoring
`timescale 1ns/1ps
`include "rbs_cfg.svh"

module rbs_core #(
  parameter bit ALL_RAM = 1'b0,
  parameter bit WAKE_OPT = 1'b1,
  parameter int unsigned HALT_DIV = 8,
  parameter int unsigned STOP_EXIT_CYC =
    `RBS_STOP_EXIT_US * `RBS_CLK_MHZ
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic ext_irq_one_n,
  input wire logic ext_irq_two_n,
  input wire logic ext_irq_three_n,
  input wire logic ext_irq_four_n,
  input wire logic serial_rx_one,
  input wire logic serial_tx_one,
  input wire logic serial_rx_two,
  input wire logic serial_tx_two,
  input wire logic host_rx,
  input wire logic host_tx,
  input wire logic boot_select_low,
  input wire logic boot_select_high,
  input wire logic exec_halt,
  input wire logic exec_stop,
  input wire logic boot_done,
  input wire logic [39:0] boot_sig,
  output logic [15:0] fetch_addr,
  output logic fetch_valid,
  output logic core_run,
  output logic clk_run,
  output logic system_clock_out,
  output logic boot_go,
  output logic [3:0] boot_code,
  output logic [15:0] boot_src,
  output logic [15:0] boot_dst,
  output logic [15:0] boot_count,
  output logic [39:0] general_reg_seven,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ==========================================================
  // build checks
  // the RAM-only build has a fixed idle ratio; the exit counter is 16 bits, the idle divider counter 4 bits
  generate
    if (HALT_DIV < 1 || HALT_DIV > 16 ||
        (ALL_RAM && HALT_DIV != `RBS_RAM_HALT_DIV) ||
        STOP_EXIT_CYC < 1 || STOP_EXIT_CYC > 65535) begin : g_bad
      $error("rbs_core: unsupported parameter value");
    end
  endgenerate

  localparam logic [3:0] DIV_LAST = 4'(HALT_DIV - 1);
  localparam logic [15:0] STOP_LAST = 16'(STOP_EXIT_CYC - 1);
  localparam logic [3:0] HOST_CODE =
    ALL_RAM ? `RBS_C_HOST_RAM : `RBS_C_HOST_ROM;

  rbs_pkg::rbs_state_s s_r;
  rbs_pkg::rbs_state_s s_nxt;

  logic [3:0] rise;
  logic [9:0] ev;
  logic [9:0] hit;
  logic [3:0] idx;
  logic stop_release_pin;
  logic do_wr;
  logic wcall;
  logic ok_op;
  logic [15:0] op_src;
  logic [15:0] op_dst;
  logic [31:0] rmux;
  logic rhit;

  // ==========================================================
  // helpers
  // byte-lane merge for 16-bit registers
  function automatic logic [15:0] wr16(input logic [15:0] old,
                                       input logic [31:0] d,
                                       input logic [3:0] st);
    logic [15:0] r;
    r = old;
    if (st[0]) r[7:0] = d[7:0];
    if (st[1]) r[15:8] = d[15:8];
    return r;
  endfunction

  // whole span must lie in one RAM region, never both
  function automatic logic one_rgn(input logic [15:0] a,
                                   input logic [15:0] c);
    logic [16:0] e;
    e = {1'b0, a} + {1'b0, c} - 17'h00001;
    return (c != 16'h0000) &&
      ((a >= `RBS_LOW_LO && e <= {1'b0, `RBS_LOW_HI}) ||
       (a >= `RBS_HIGH_LO && e <= {1'b0, `RBS_HIGH_HI})); // RL20
  endfunction

  // ==========================================================
  // event sources
  // first sync stage feeds only the second; edges come from s2/prv
  assign rise = s_r.s2 & ~s_r.prv;
  assign ev = {host_tx, host_rx, serial_tx_two, serial_rx_two,
               serial_tx_one, serial_rx_one, rise};
  assign hit = s_r.pend & s_r.mask;
  assign stop_release_pin =
    WAKE_OPT && (s_r.st == rbs_pkg::RBS_STOP) && rise[3]; // RL12 RL13

  // lowest source index wins
  always_comb begin
    idx = 4'h0;
    for (int i = 9; i >= 0; i--) begin
      if (hit[i]) idx = 4'(i);
    end
  end

  // ==========================================================
  // reboot call decode
  assign do_wr = s_r.awok && s_r.wok && !s_r.bv;
  assign wcall = do_wr && (s_r.awa == `RBS_R_CALL);

  // pointer roles swap between X and Y sourced self reboot
  always_comb begin
    op_src = s_r.pointer_seven;
    op_dst = s_r.pointer_three;
    ok_op = 1'b0;
    case (s_r.wd[3:0])
      `RBS_C_SELF_YW, `RBS_C_SELF_YB: begin
        ok_op = !ALL_RAM; // RL17
      end
      `RBS_C_SELF_XW, `RBS_C_SELF_XB: begin
        op_src = s_r.pointer_three;
        op_dst = s_r.pointer_seven;
        ok_op = !ALL_RAM; // RL17
      end
      `RBS_C_SIG: begin
        op_src = 16'h0000;
        ok_op = ALL_RAM; // RL19
      end
      default: begin
        op_src = 16'h0000;
        ok_op = (s_r.wd[3:0] == HOST_CODE); // RL18
      end
    endcase
    ok_op = ok_op && one_rgn(op_dst, s_r.steps); // RL20
  end

  // ==========================================================
  // next-state logic
  always_comb begin
    s_nxt = s_r;
    s_nxt.fp = 1'b0;
    s_nxt.go = 1'b0;
    s_nxt.s1 = ~{ext_irq_four_n, ext_irq_three_n,
                 ext_irq_two_n, ext_irq_one_n};
    s_nxt.s2 = s_r.s1;
    s_nxt.prv = s_r.s2;
    s_nxt.b1 = {boot_select_high, boot_select_low};
    s_nxt.b2 = s_r.b1;
    s_nxt.sco = ~s_r.sco;
    s_nxt.dcnt = 4'h0;

    // controller
    case (s_r.st)
      rbs_pkg::RBS_BOOT: begin
        s_nxt.cnt = s_r.cnt - 16'h0001;
        if (s_r.cnt == 16'h0000) begin
          s_nxt.bmode = s_r.b2;
          s_nxt.fp = 1'b1;
          s_nxt.core_run = 1'b1;
          s_nxt.steps = 16'h0000;
          case (s_r.b2) // RL21
            2'b01: begin
              s_nxt.code = `RBS_C_BOOT_HOST; // RL16
              s_nxt.src = 16'h0000;
              s_nxt.go = 1'b1;
              s_nxt.fa = 16'h0000; // RL14
              s_nxt.st = rbs_pkg::RBS_BOOTW;
            end
            2'b11: begin
              s_nxt.code = `RBS_C_BOOT_SELF;
              s_nxt.src = `RBS_YPARAM; // RL15
              s_nxt.go = 1'b1;
              s_nxt.fa = 16'h0000; // RL14
              s_nxt.st = rbs_pkg::RBS_BOOTW;
            end
            default: begin
              // prohibited pattern flagged, run without boot
              s_nxt.err = (s_r.b2 == 2'b10);
              s_nxt.fa = `RBS_VEC_BASE; // RL3
              s_nxt.st = rbs_pkg::RBS_RUN;
            end
          endcase
        end
      end
      rbs_pkg::RBS_BOOTW: begin
        if (boot_done) begin
          s_nxt.fa = `RBS_VEC_BASE; // RL1 RL3
          s_nxt.fp = 1'b1;
          s_nxt.st = rbs_pkg::RBS_RUN;
        end
      end
      rbs_pkg::RBS_RUN: begin
        if (wcall) begin
          // call wins this cycle; any interrupt waits pending
          s_nxt.err = !ok_op;
          if (ok_op) begin
            s_nxt.code = s_r.wd[3:0];
            s_nxt.src = op_src;
            s_nxt.dst = op_dst;
            s_nxt.go = 1'b1;
            s_nxt.fa = {12'h000, s_r.wd[3:0]}; // RL14
            s_nxt.fp = 1'b1;
            s_nxt.st = rbs_pkg::RBS_OPW;
          end
        end else if (exec_stop) begin
          s_nxt.core_run = 1'b0;
          s_nxt.clk_run = 1'b0; // RL9
          s_nxt.sco = 1'b0; // RL9
          s_nxt.st = rbs_pkg::RBS_STOP;
        end else if (exec_halt) begin
          s_nxt.core_run = 1'b0; // RL4
          s_nxt.st = rbs_pkg::RBS_HALT;
        end else if (hit != 10'h000) begin
          s_nxt.fa = `RBS_VEC_IRQ + {10'h000, idx, 2'b00}; // RL2
          s_nxt.fp = 1'b1;
          s_nxt.pend[idx] = 1'b0;
        end
      end
      rbs_pkg::RBS_OPW: begin
        if (boot_done) begin
          if (s_r.code == `RBS_C_SIG) begin
            s_nxt.general_reg_seven = boot_sig; // RL19
          end
          s_nxt.st = rbs_pkg::RBS_RUN;
        end
      end
      rbs_pkg::RBS_HALT: begin
        // divided clock: one normal-width high every HALT_DIV cycles
        s_nxt.dcnt = (s_r.dcnt == DIV_LAST) ? 4'h0
                     : s_r.dcnt + 4'h1; // RL7
        s_nxt.sco = (s_r.dcnt == DIV_LAST); // RL8
        if (hit != 10'h000) begin
          s_nxt.cnt = `RBS_HALT_EXIT_CYC - 16'h0001;
          s_nxt.st = rbs_pkg::RBS_HEXIT; // RL5
        end
      end
      rbs_pkg::RBS_HEXIT: begin
        // full-rate clock already back; vector taken in run
        s_nxt.cnt = s_r.cnt - 16'h0001; // RL6 RL22
        if (s_r.cnt == 16'h0000) begin
          s_nxt.core_run = 1'b1;
          s_nxt.st = rbs_pkg::RBS_RUN;
        end
      end
      rbs_pkg::RBS_STOP: begin
        s_nxt.sco = 1'b0;
        if (stop_release_pin) begin
          s_nxt.clk_run = 1'b1;
          s_nxt.cnt = STOP_LAST; // RL11
          s_nxt.st = rbs_pkg::RBS_SEXIT; // RL10
        end
      end
      rbs_pkg::RBS_SEXIT: begin
        // oscillator and PLL settle before the core resumes
        s_nxt.cnt = s_r.cnt - 16'h0001; // RL11
        if (s_r.cnt == 16'h0000) begin
          s_nxt.core_run = 1'b1;
          s_nxt.st = rbs_pkg::RBS_RUN;
        end
      end
      default: begin
        s_nxt.st = rbs_pkg::RBS_BOOT;
      end
    endcase

    // new events are set after the clear, so set wins; nothing
    // latches while stopped, so release never vectors
    if (s_r.st != rbs_pkg::RBS_STOP) begin
      s_nxt.pend = s_nxt.pend | ev; // RL12
    end

    // write channel: address and data taken in either order
    if (!s_r.awok && !s_r.bv && s_axi_awvalid) begin
      s_nxt.awok = 1'b1;
      s_nxt.awa = {s_axi_awaddr[7:2], 2'b00};
    end
    if (!s_r.wok && !s_r.bv && s_axi_wvalid) begin
      s_nxt.wok = 1'b1;
      s_nxt.wd = s_axi_wdata;
      s_nxt.ws = s_axi_wstrb;
    end
    if (do_wr) begin
      s_nxt.awok = 1'b0;
      s_nxt.wok = 1'b0;
      s_nxt.bv = 1'b1;
      s_nxt.bresp = 2'b00;
      case (s_r.awa)
        `RBS_R_MASK: s_nxt.mask =
          10'(wr16({6'h00, s_r.mask}, s_r.wd, s_r.ws));
        `RBS_R_STEP: s_nxt.steps = wr16(s_r.steps, s_r.wd, s_r.ws);
        `RBS_R_PTR3: s_nxt.pointer_three =
          wr16(s_r.pointer_three, s_r.wd, s_r.ws);
        `RBS_R_PTR7: s_nxt.pointer_seven =
          wr16(s_r.pointer_seven, s_r.wd, s_r.ws);
        `RBS_R_CALL, `RBS_R_STAT, `RBS_R_PEND, `RBS_R_RES: begin
        end
        default: s_nxt.bresp = 2'b10;
      endcase
    end
    if (s_r.bv && s_axi_bready) s_nxt.bv = 1'b0;

    // read channel
    if (!s_r.rv && s_axi_arvalid) begin
      s_nxt.rv = 1'b1;
      s_nxt.rd = rmux;
      s_nxt.rresp = rhit ? 2'b00 : 2'b10;
    end else if (s_r.rv && s_axi_rready) begin
      s_nxt.rv = 1'b0;
    end
  end

  // read decode; unmapped words read zero with SLVERR
  always_comb begin
    rhit = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      `RBS_R_MASK: rmux = {22'h000000, s_r.mask};
      `RBS_R_STEP: rmux = {16'h0000, s_r.steps};
      `RBS_R_PTR3: rmux = {16'h0000, s_r.pointer_three};
      `RBS_R_PTR7: rmux = {16'h0000, s_r.pointer_seven};
      `RBS_R_CALL: rmux = {28'h0000000, s_r.code};
      `RBS_R_STAT: rmux = {24'h000000, s_r.err, s_r.bmode,
                           s_r.clk_run, s_r.core_run, s_r.st};
      `RBS_R_PEND: rmux = {22'h000000, s_r.pend};
      `RBS_R_RES: rmux = s_r.general_reg_seven[31:0];
      default: begin
        rmux = 32'h00000000;
        rhit = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // state register; reset restarts boot from the top
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.cnt <= `RBS_SETTLE;
      s_r.clk_run <= 1'b1;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign fetch_addr = s_r.fa;
  assign fetch_valid = s_r.fp;
  assign core_run = s_r.core_run;
  assign clk_run = s_r.clk_run;
  assign system_clock_out = s_r.sco;
  assign boot_go = s_r.go;
  assign boot_code = s_r.code;
  assign boot_src = s_r.src;
  assign boot_dst = s_r.dst;
  assign boot_count = s_r.steps;
  assign general_reg_seven = s_r.general_reg_seven;
  assign s_axi_awready = !s_r.awok && !s_r.bv;
  assign s_axi_wready = !s_r.wok && !s_r.bv;
  assign s_axi_bvalid = s_r.bv;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = !s_r.rv;
  assign s_axi_rvalid = s_r.rv;
  assign s_axi_rdata = s_r.rd;
  assign s_axi_rresp = s_r.rresp;

  // ==========================================================
  // assertions
  a_fetch_window: assert property (@(posedge aclk) disable iff (!aresetn)
    s_r.fp |-> (s_r.fa <= `RBS_BOOTROM_LAST ||
     (s_r.fa >= `RBS_VEC_BASE && s_r.fa <= `RBS_VEC_LAST)))
    else $error("fetch outside boot ROM and vectors"); // RL1

  a_irq_slot: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && s_r.st == rbs_pkg::RBS_RUN && !wcall && !exec_stop
    && !exec_halt && s_r.pend[4] && s_r.mask[4] && hit[3:0] == 4'h0
    |=> s_r.fp && s_r.fa == 16'h0220)
    else $error("serial slot vector wrong"); // RL2

  a_reset_entry: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && s_r.st == rbs_pkg::RBS_BOOTW && boot_done
    |=> s_r.fp && s_r.fa == `RBS_VEC_BASE
    && s_r.st == rbs_pkg::RBS_RUN)
    else $error("boot end did not enter 0x200"); // RL3

  a_halt_freeze: assert property (@(posedge aclk) disable iff (!aresetn)
    s_r.st == rbs_pkg::RBS_HALT |-> !core_run && clk_run)
    else $error("halt must freeze core only"); // RL4

  a_halt_wake: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && s_r.st == rbs_pkg::RBS_HALT && hit != 10'h000
    |=> s_r.st == rbs_pkg::RBS_HEXIT)
    else $error("interrupt did not leave halt"); // RL5

  a_halt_delay: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && $rose(s_r.st == rbs_pkg::RBS_HEXIT)
    |-> (!core_run && !s_r.fp)[*8])
    else $error("halt exit too quick"); // RL6

  a_clk_high: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && s_r.st == rbs_pkg::RBS_HALT && HALT_DIV > 1
    && s_nxt.st == rbs_pkg::RBS_HALT && s_r.sco |=> !s_r.sco)
    else $error("idle clock high over one cycle"); // RL8

  a_stop_dead: assert property (@(posedge aclk) disable iff (!aresetn)
    s_r.st == rbs_pkg::RBS_STOP |-> !clk_run && !core_run && !s_r.sco)
    else $error("stop left clock running"); // RL9

  a_stop_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && s_r.st == rbs_pkg::RBS_STOP && !stop_release_pin
    |=> s_r.st == rbs_pkg::RBS_STOP && !s_r.fp)
    else $error("stop left without release"); // RL10 RL13

  a_one_region: assert property (@(posedge aclk) disable iff (!aresetn)
    s_r.go && s_r.st == rbs_pkg::RBS_OPW |-> one_rgn(s_r.dst, s_r.steps))
    else $error("operation spans both regions"); // RL20

endmodule

// *** sim/rbs_partner.sv ***
/*
  Far-side model: external interrupt pins, serial and host event
  sources, boot select pins.
  Assumes the bench raises fire for one cycle with src set.
*/
`timescale 1ns/1ps

module rbs_partner (
  input wire logic aclk,
  input wire logic fire,
  input wire logic [3:0] src,
  input wire logic [1:0] bsel,
  output logic [3:0] irq_n,
  output logic [5:0] ev,
  output logic [1:0] bs
);
  logic [2:0] hold;

  // ==========================================================
  // pins
  // interrupt lines are pulled up, so a released pin rests high
  initial begin
    irq_n = 4'hF;
    ev = 6'h00;
    hold = 3'h0;
  end

  assign bs = bsel;

  // pin held low five cycles so the two-stage sync cannot miss it
  always @(posedge aclk) begin
    ev <= 6'h00;
    if (hold != 3'h0) begin
      hold <= hold - 3'h1;
    end else begin
      irq_n <= 4'hF;
    end
    if (fire && src < 4'h4) begin
      irq_n[src[1:0]] <= 1'b0;
      hold <= 3'h4;
    end else if (fire) begin
      ev[src - 4'h4] <= 1'b1;
    end
  end
endmodule

// *** sim/rbs_core_bench.sv ***
/*
  Self-checking bench: boot modes, register bus, vectoring, reboot
  calls, HALT and STOP.
  Assumes rbs_partner on the pins and a short stop exit count.
*/
`timescale 1ns/1ps
`include "rbs_cfg.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_fail++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end

module rbs_core_bench;
  logic aclk, aresetn, ce, fire, fetch_valid, core_run, clk_run;
  logic system_clock_out, boot_go;
  logic [2:0] pl;
  logic [3:0] src, boot_code, s_axi_wstrb;
  logic [1:0] bsel, s_axi_bresp, s_axi_rresp, rresp, wresp;
  logic [15:0] fetch_addr, boot_src, boot_dst, boot_count, last_fa;
  logic [39:0] boot_sig, general_reg_seven;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  wire [3:0] irq_n;
  wire [5:0] ev;
  wire [1:0] bs;
  wire ext_irq_one_n = irq_n[0], ext_irq_two_n = irq_n[1];
  wire ext_irq_three_n = irq_n[2], ext_irq_four_n = irq_n[3];
  wire serial_rx_one = ev[0], serial_tx_one = ev[1];
  wire serial_rx_two = ev[2], serial_tx_two = ev[3];
  wire host_rx = ev[4], host_tx = ev[5];
  wire boot_select_low = bs[0], boot_select_high = bs[1];
  wire exec_halt = pl[0], exec_stop = pl[1], boot_done = pl[2];
  int n_fail, n_tests, n_fetch, n_go;

  // short stop exit keeps the run brief
  rbs_core #(.STOP_EXIT_CYC(20)) u_dut (.*);
  rbs_partner u_far (.*);

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // count fetch and boot pulses as they happen
  always @(posedge aclk) begin
    if (fetch_valid === 1'b1) begin
      last_fa <= fetch_addr;
      n_fetch <= n_fetch + 1;
    end
    if (boot_go === 1'b1) n_go <= n_go + 1;
  end

  // ==========================================================
  // helpers
  task automatic conclude;
    if (n_fail == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wcnt(ref int n, input int lim);
    int c0;
    c0 = n;
    for (int i = 0; i < lim && n == c0; i++) @(posedge aclk);
  endtask

  // readies seen at the edge itself; only the watchdog ends a wait
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic tb;
    tb = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!tb) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      tb = s_axi_bvalid;
      wresp = s_axi_bresp;
      if (tb) s_axi_bready <= 1'b0;
    end
  endtask

  task automatic rd(input logic [7:0] a);
    logic tb;
    tb = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!tb) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      tb = s_axi_rvalid;
      rdat = s_axi_rdata;
      rresp = s_axi_rresp;
      if (tb) s_axi_rready <= 1'b0;
    end
  endtask

  task automatic pulse(input int i);
    @(posedge aclk);
    pl[i] <= 1'b1;
    @(posedge aclk);
    pl <= 3'h0;
  endtask

  task automatic fire_src(input logic [3:0] s);
    @(posedge aclk);
    src <= s;
    fire <= 1'b1;
    @(posedge aclk);
    fire <= 1'b0;
  endtask

  task automatic rst(input logic [1:0] b);
    @(posedge aclk);
    bsel <= b;
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  task automatic run_for(output int k);
    k = 0;
    while (core_run !== 1'b1 && k < 200) begin
      @(posedge aclk);
      k++;
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic t_boot(input logic [1:0] b);
    rst(b);
    if (b[0]) begin
      wcnt(n_go, 60);
      `CHK(boot_code, b[1] ? `RBS_C_BOOT_SELF : `RBS_C_BOOT_HOST)
      if (b[1]) `CHK(boot_src, `RBS_YPARAM)
      pulse(2);
    end
    wcnt(n_fetch, 60);
    `CHK(last_fa, `RBS_VEC_BASE)
    rd(`RBS_R_STAT);
    `CHK(rdat[7], b == 2'b10)
  endtask

  task automatic t_irq;
    int g;
    rd(`RBS_R_MASK);
    `CHK(rdat, 32'h0)
    wr(`RBS_R_MASK, 32'hFFFFFFFF);
    `CHK(wresp, 2'b00)
    rd(`RBS_R_MASK);
    `CHK(rdat, 32'h3FF)
    rd(8'h20);
    `CHK({rresp, rdat}, {2'b10, 32'h0})
    wr(8'h20, 32'h1);
    `CHK(wresp, 2'b10)
    for (int i = 0; i < 10; i++) begin
      fire_src(4'(i));
      wcnt(n_fetch, 30);
      `CHK(last_fa, `RBS_VEC_IRQ + 16'(4 * i))
    end
    // a masked event must wait, not vanish
    wr(`RBS_R_MASK, 32'h0);
    g = n_fetch;
    fire_src(4'h5);
    wcnt(n_fetch, 20);
    `CHK(n_fetch, g)
    wr(`RBS_R_MASK, 32'h3FF);
    wcnt(n_fetch, 20);
    `CHK(last_fa, 16'h0224)
  endtask

  task automatic t_call;
    int g;
    wr(`RBS_R_STEP, 32'h4);
    wr(`RBS_R_PTR3, 32'h0300);
    wr(`RBS_R_PTR7, 32'h0800);
    for (int c = 1; c <= 5; c++) begin
      g = n_go;
      wr(`RBS_R_CALL, 32'(c));
      repeat (2) @(posedge aclk);
      `CHK(n_go, g + 1)
      `CHK({boot_code, boot_count, last_fa}, {4'(c), 16'h4, 16'(c)})
      `CHK(boot_src, c == 5 ? 16'h0 : (c[0] ? 16'h0800 : 16'h0300))
      `CHK(boot_dst, (c == 5 || c[0]) ? 16'h0300 : 16'h0800)
      pulse(2);
      repeat (4) @(posedge aclk);
    end
    // last word 0x0FFF is still inside the low region
    g = n_go;
    wr(`RBS_R_PTR3, 32'h0FFC);
    wr(`RBS_R_CALL, 32'h5);
    repeat (2) @(posedge aclk);
    `CHK(n_go, g + 1)
    pulse(2);
    repeat (4) @(posedge aclk);
    g = n_go;
    wr(`RBS_R_CALL, 32'h6);
    wr(`RBS_R_CALL, 32'h9);
    wr(`RBS_R_PTR3, 32'h0FFE);
    wr(`RBS_R_CALL, 32'h5);
    repeat (3) @(posedge aclk);
    `CHK(n_go, g)
    `CHK(general_reg_seven, 40'h0)
    rd(`RBS_R_STAT);
    `CHK(rdat[7], 1'b1)
  endtask

  task automatic t_halt;
    int hi, k;
    logic prv, dbl;
    hi = 0;
    prv = 1'b0;
    dbl = 1'b0;
    pulse(0);
    repeat (2) @(posedge aclk);
    rd(`RBS_R_STAT);
    `CHK(rdat[4:0], 5'h14)
    for (int i = 0; i < 16; i++) begin
      @(negedge aclk);
      hi += int'(system_clock_out);
      if (system_clock_out && prv) dbl = 1'b1;
      prv = system_clock_out;
    end
    `CHK(hi, 16 / `RBS_RAM_HALT_DIV)
    `CHK(dbl, 1'b0)
    fire_src(4'h0);
    run_for(k);
    `CHK(k >= 30 && k <= 45, 1'b1)
    wcnt(n_fetch, 10);
    `CHK(last_fa, `RBS_VEC_IRQ)
  endtask

  task automatic t_stop;
    int g, k;
    pulse(1);
    repeat (2) @(posedge aclk);
    `CHK({clk_run, core_run, system_clock_out}, 3'b000)
    g = n_fetch;
    fire_src(4'h4);
    fire_src(4'h0);
    repeat (10) @(posedge aclk);
    `CHK({n_fetch, clk_run}, {g, 1'b0})
    fire_src(4'h3);
    run_for(k);
    `CHK(k >= 20 && k <= 40, 1'b1)
    wcnt(n_fetch, 10);
    `CHK(n_fetch, g)
    rd(`RBS_R_MASK);
    `CHK(rdat, 32'h3FF)
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {aresetn, fire, src, bsel, pl} = '0;
    ce = 1'b1;
    boot_sig = 40'h5AA5C33C0F;
    s_axi_wstrb = 4'hF;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
    {s_axi_arvalid, s_axi_rready} = 2'b00;
    {n_fail, n_tests, n_fetch, n_go} = '0;
    last_fa = 16'h0;
    t_boot(2'b01);
    t_boot(2'b11);
    t_boot(2'b10);
    t_boot(2'b00);
    t_irq;
    t_call;
    t_halt;
    t_stop;
    conclude;
  end

  // the whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    conclude;
  end
endmodule
